// ==== common/dds_cmd_regs.svh ====
/*
  Constants of the serial command decoder: bus offsets, command word fields,
  status bit positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DDS_CMD_REGS_SVH
`define DDS_CMD_REGS_SVH

// bus register offsets (byte addresses)
`define OFF_CMD_WORD 8'h00
`define OFF_STATUS 8'h04
`define OFF_PHASE_OUT 8'h08
`define OFF_FREQ_ACTIVE 8'h0c
`define OFF_LAST_WORD 8'h10

// command word fields
`define WORD_BITS 5'd16
`define ADDR_HI 11
`define ADDR_LO 8
`define DATA_HI 7
`define BIT_SYNC 13
`define BIT_PICK_SRC 12
`define BIT_SLEEP 13
`define BIT_ACC_RESET 12
`define BIT_WIPE 11
`define BIT_FPICK 11
`define BIT_PPICK_HI 10
`define BIT_PPICK_LO 9
`define ADDR_PHASE_BIT 3

// status register bit positions
`define ST_SYNC 0
`define ST_PICK_SRC 1
`define ST_SLEEP 2
`define ST_ACC_RESET 3
`define ST_FSEL 4
`define ST_PSEL_LO 5
`define ST_LOAD_BUSY 7

// reset values and timing
`define CTRL_RESET 1'b0
`define SYNC_EXTRA_CYCLES 2'd2

`endif

// ==== common/dds_cmd_pkg.sv ====
/*
  Types of the serial command decoder: command classes and the state
  structs of its three modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package dds_cmd_pkg;

  typedef enum logic [3:0] {
    CMD_PHASE_DIRECT, CMD_PHASE_DEFER, CMD_FREQ_DIRECT, CMD_FREQ_DEFER,
    CMD_PHASE_PICK, CMD_FREQ_PICK, CMD_BOTH_PICK, CMD_RESERVED,
    CMD_CONTROL, CMD_POWER
  } cmd_kind_t;

  typedef struct packed {
    logic [2:0] clk_s;
    logic [2:0] dat_s;
    logic [2:0] fs_s;
    logic clk_lvl;
    logic fs_lvl;
    logic [15:0] shift;
    logic [4:0] cnt;
    logic [15:0] word;
    logic valid;
  } rx_state_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [11:0] phase;
  } acc_state_t;

  typedef struct packed {
    logic [1:0][31:0] tuning;
    logic [3:0][11:0] phase_off;
    logic [15:0] defer_freq;
    logic [15:0] defer_phase;
    logic ld_pend;
    logic ld_phase;
    logic [3:0] ld_addr;
    logic [15:0] ld_value;
    logic [1:0] ld_wait;
    logic sync_on;
    logic pick_from_bits;
    logic freq_bit;
    logic [1:0] phase_bits;
    logic sleep;
    logic acc_reset;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_lvl;
    logic [1:0][2:0] pin_dly;
    logic apb_pend;
    logic [15:0] apb_word;
    logic [15:0] last_word;
    logic [31:0] rdata;
    logic err;
  } core_state_t;

endpackage

`default_nettype wire

// ==== common/cmd_word_if.sv ====
/*
  Carrier of received command words from the serial receiver to the core.
  Assumes both ends run on the same bus clock; valid is a one-cycle pulse.
*/
`default_nettype none

interface cmd_word_if;
  logic [15:0] word;
  logic valid;
  modport source (output word, output valid);
  modport sink (input word, input valid);
endinterface

`default_nettype wire

// ==== logic/serial_word_rx.sv ====
/*
  Serial word receiver: oversamples the host shift clock, data and frame
  strobe on pclk and assembles 16-bit words, msb first.
  Assumes the shift clock is several times slower than pclk.
*/
`default_nettype none
`include "dds_cmd_regs.svh"

module serial_word_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic frame_strobe_n,
  cmd_word_if.source words
);

  // shift clock idles high: its stages start high too, so no false fall after reset
  localparam dds_cmd_pkg::rx_state_t RX_RST = '{clk_s: 3'h7, fs_s: 3'h7, fs_lvl: 1'b1, clk_lvl: 1'b1, default: '0};

  dds_cmd_pkg::rx_state_t state_reg;
  dds_cmd_pkg::rx_state_t state_next;
  logic fall;

  always_comb begin
    state_next = state_reg;
    state_next.valid = 1'b0;
    // first stage feeds only the second
    state_next.clk_s = {state_reg.clk_s[1:0], serial_clk};
    state_next.dat_s = {state_reg.dat_s[1:0], serial_in};
    state_next.fs_s = {state_reg.fs_s[1:0], frame_strobe_n};
    if (state_reg.clk_s[1] == state_reg.clk_s[2]) begin
      state_next.clk_lvl = state_reg.clk_s[2];
    end
    if (state_reg.fs_s[1] == state_reg.fs_s[2]) begin
      state_next.fs_lvl = state_reg.fs_s[2];
    end
    fall = state_reg.clk_lvl & (state_reg.clk_s[1] == state_reg.clk_s[2]) & ~state_reg.clk_s[2];
    if (state_reg.fs_lvl) begin
      state_next.cnt = 5'h00;
    // [R17] one bit per falling edge
    end else if (fall && state_reg.cnt < `WORD_BITS) begin
      state_next.shift = {state_reg.shift[14:0], state_reg.dat_s[2]};
      state_next.cnt = state_reg.cnt + 5'h01;
      if (state_reg.cnt == `WORD_BITS - 5'h01) begin
        state_next.word = {state_reg.shift[14:0], state_reg.dat_s[2]};
        state_next.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RX_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign words.word = state_reg.word;
  assign words.valid = state_reg.valid;

endmodule

`default_nettype wire

// ==== logic/phase_accum.sv ====
/*
  Phase accumulator with phase offset adder feeding the sine lookup.
  Assumes step and offset are stable, registered values.
*/
`default_nettype none

module phase_accum (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clear,
  input wire logic [31:0] step,
  input wire logic [11:0] offset,
  output logic [11:0] phase
);

  dds_cmd_pkg::acc_state_t state_reg;
  dds_cmd_pkg::acc_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // [R15] zero accumulator while held; phase output still carries the offset
    if (clear) begin
      state_next.acc = 32'h0000_0000;
    // [R21] accumulate while clocks run
    end else if (run) begin
      state_next.acc = state_reg.acc + step;
    end
    state_next.phase = state_reg.acc[31:20] + offset;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign phase = state_reg.phase;

endmodule

`default_nettype wire

// ==== logic/dds_command_decoder.sv ====
/*
  Serial command decoder of a direct digital synthesiser: receives 16-bit
  command words from a framed serial link (or from the bus), loads tuning
  and phase registers through the defer byte, picks the active registers by
  bits or pins and drives power-down, accumulator reset and the phase
  accumulator. Software reaches status and a command inject port over APB.
  Assumes an APB master on pclk and a host link far slower than pclk.
*/
`default_nettype none
`include "dds_cmd_regs.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// [R1] bits 15-12 command, 11-8 address, 7-0 data, msb first
// [R2] code 0: defer byte plus new byte written into addressed phase register
// [R3] code 1: byte stored in phase defer register only
// [R4] code 2: defer byte plus new byte written into addressed tuning half
// [R5] code 3: byte stored in frequency defer register only
// [R6] code 4: bits 9,10 become phase pick bits, used when pick-from-bits set
// [R7] code 5: bit 11 becomes frequency pick bit, used when pick-from-bits set
// [R8] code 6: all three pick bits updated in one write
// [R9] host never sends code 7; it is reserved and ignored here
// [R10] top bits 10: bit 13 sets sync mode, bit 12 pick-from-bits, rest ignored
// [R11] sync mode: pins and loads aligned to pclk, two extra cycles
// [R12] no sync: loads and pin sampling take effect without extra delay
// [R13] pick-from-bits chooses bits, otherwise pins, for active registers
// [R14] top bits 11, bit 13: sleep, stop clocks, converter and reference off
// [R15] power command bit 12 holds accumulator at zero phase
// [R16] power command bit 11 clears sync and pick-from-bits, self-clearing
// [R17] frame low, sixteen bits captured on falling shift-clock edges
// [R18] address 0-7 tuning bytes, 8-15 phase register bytes
// [R19] phase pick lo is lsb of phase index; frequency pick 0/1 direct
// [R20] direct transfer lands in destination at next pclk edge
// [R21] 32-bit accumulator, 12-bit offset added to top bits, 12-bit result
// [R22] sync and pick-from-bits are zero after reset
module dds_command_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic frame_strobe_n,
  input wire logic freq_pick,
  input wire logic phase_pick_lo,
  input wire logic phase_pick_hi,
  output logic [11:0] sine_phase,
  output logic power_down,
  output logic reference_output
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  dds_cmd_pkg::core_state_t state_reg;
  dds_cmd_pkg::core_state_t state_next;
  cmd_word_if rx_words ();
  logic active_fsel;
  logic [1:0] active_psel;
  logic [2:0] pin_src;
  logic [31:0] active_step;
  logic [11:0] active_offset;
  logic setup;
  logic access;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // [R1] command class from top bits
  function automatic dds_cmd_pkg::cmd_kind_t kind_of(input logic [15:0] w);
    dds_cmd_pkg::cmd_kind_t k;
    k = dds_cmd_pkg::CMD_RESERVED;
    if (!w[15]) begin
      unique case (w[14:12])
        3'h0: k = dds_cmd_pkg::CMD_PHASE_DIRECT;
        3'h1: k = dds_cmd_pkg::CMD_PHASE_DEFER;
        3'h2: k = dds_cmd_pkg::CMD_FREQ_DIRECT;
        3'h3: k = dds_cmd_pkg::CMD_FREQ_DEFER;
        3'h4: k = dds_cmd_pkg::CMD_PHASE_PICK;
        3'h5: k = dds_cmd_pkg::CMD_FREQ_PICK;
        3'h6: k = dds_cmd_pkg::CMD_BOTH_PICK;
        3'h7: k = dds_cmd_pkg::CMD_RESERVED;
      endcase
    end else if (!w[14]) begin
      k = dds_cmd_pkg::CMD_CONTROL;
    end else begin
      k = dds_cmd_pkg::CMD_POWER;
    end
    return k;
  endfunction

  // destination write of an assembled 16-bit value
  function automatic dds_cmd_pkg::core_state_t commit_load(
    input dds_cmd_pkg::core_state_t s,
    input logic is_phase,
    input logic [3:0] addr,
    input logic [15:0] value
  );
    dds_cmd_pkg::core_state_t t;
    t = s;
    // [R18] address map of destinations
    if (is_phase) begin
      // top four bits of the high byte are dropped: registers are 12 bits
      t.phase_off[addr[2:1]] = value[11:0];
    end else if (addr[1]) begin
      t.tuning[addr[2]][31:16] = value;
    end else begin
      t.tuning[addr[2]][15:0] = value;
    end
    return t;
  endfunction

  // one command word applied to the state
  function automatic dds_cmd_pkg::core_state_t apply_word(
    input dds_cmd_pkg::core_state_t s,
    input logic [15:0] w
  );
    dds_cmd_pkg::core_state_t t;
    logic [3:0] addr;
    logic [7:0] data;
    logic load;
    logic is_phase;
    logic [15:0] value;
    t = s;
    addr = w[`ADDR_HI:`ADDR_LO];
    data = w[`DATA_HI:0];
    load = 1'b0;
    is_phase = 1'b0;
    value = 16'h0000;
    t.last_word = w;
    unique case (kind_of(w))
      // [R2] phase direct transfer
      dds_cmd_pkg::CMD_PHASE_DIRECT: begin
        t.defer_phase[addr[0]*8 +: 8] = data;
        load = addr[`ADDR_PHASE_BIT];
        is_phase = 1'b1;
        value = t.defer_phase;
      end
      // [R3] phase defer byte only
      dds_cmd_pkg::CMD_PHASE_DEFER: begin
        t.defer_phase[addr[0]*8 +: 8] = data;
      end
      // [R4] frequency direct transfer
      dds_cmd_pkg::CMD_FREQ_DIRECT: begin
        t.defer_freq[addr[0]*8 +: 8] = data;
        load = !addr[`ADDR_PHASE_BIT];
        value = t.defer_freq;
      end
      // [R5] frequency defer byte only
      dds_cmd_pkg::CMD_FREQ_DEFER: begin
        t.defer_freq[addr[0]*8 +: 8] = data;
      end
      // [R6] phase pick bits
      dds_cmd_pkg::CMD_PHASE_PICK: begin
        t.phase_bits = {w[`BIT_PPICK_HI], w[`BIT_PPICK_LO]};
      end
      // [R7] frequency pick bit
      dds_cmd_pkg::CMD_FREQ_PICK: begin
        t.freq_bit = w[`BIT_FPICK];
      end
      // [R8] all pick bits at once
      dds_cmd_pkg::CMD_BOTH_PICK: begin
        t.phase_bits = {w[`BIT_PPICK_HI], w[`BIT_PPICK_LO]};
        t.freq_bit = w[`BIT_FPICK];
      end
      // [R9] reserved test code does nothing here
      dds_cmd_pkg::CMD_RESERVED: begin
        t.last_word = w;
      end
      // [R10] sync and source bits
      dds_cmd_pkg::CMD_CONTROL: begin
        t.sync_on = w[`BIT_SYNC];
        t.pick_from_bits = w[`BIT_PICK_SRC];
      end
      dds_cmd_pkg::CMD_POWER: begin
        // [R14] sleep level
        t.sleep = w[`BIT_SLEEP];
        // [R15] accumulator hold
        t.acc_reset = w[`BIT_ACC_RESET];
        // [R16] wipe acts once, nothing stored
        if (w[`BIT_WIPE]) begin
          t.sync_on = `CTRL_RESET;
          t.pick_from_bits = `CTRL_RESET;
        end
      end
    endcase
    if (load) begin
      // [R11] sync mode delays the load
      if (s.sync_on) begin
        if (t.ld_pend) begin
          t = commit_load(t, t.ld_phase, t.ld_addr, t.ld_value);
        end
        t.ld_pend = 1'b1;
        t.ld_phase = is_phase;
        t.ld_addr = addr;
        t.ld_value = value;
        t.ld_wait = `SYNC_EXTRA_CYCLES - 2'd1;
      // [R12] [R20] load at the edge that takes the word
      end else begin
        t = commit_load(t, is_phase, addr, value);
      end
    end
    return t;
  endfunction

  // bus address decode, used by the error path only; reads decode paddr directly
  function automatic logic addr_known(input logic [7:0] a);
    return a == `OFF_CMD_WORD || a == `OFF_STATUS || a == `OFF_PHASE_OUT ||
      a == `OFF_FREQ_ACTIVE || a == `OFF_LAST_WORD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver and accumulator

  serial_word_rx rx (
    .pclk(pclk),
    .presetn(presetn),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .frame_strobe_n(frame_strobe_n),
    .words(rx_words.source)
  );

  phase_accum accum (
    .pclk(pclk),
    .presetn(presetn),
    .run(!state_reg.sleep),
    .clear(state_reg.acc_reset),
    .step(active_step),
    .offset(active_offset),
    .phase(sine_phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // active register selection

  always_comb begin
    // [R11] [R12] pins seen two cycles later in sync mode
    pin_src = state_reg.sync_on ? state_reg.pin_dly[1] : state_reg.pin_lvl;
    // [R13] bits or pins choose
    if (state_reg.pick_from_bits) begin
      active_fsel = state_reg.freq_bit;
      active_psel = state_reg.phase_bits;
    end else begin
      active_fsel = pin_src[0];
      active_psel = pin_src[2:1];
    end
    // [R19] index from pick signals
    active_step = state_reg.tuning[active_fsel];
    active_offset = state_reg.phase_off[active_psel];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  assign setup = psel && !penable;
  assign access = psel && penable;

  always_comb begin
    state_next = state_reg;
    // pin synchronisers: first stage feeds only the second
    state_next.pin_s1 = {phase_pick_hi, phase_pick_lo, freq_pick};
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_s3 = state_reg.pin_s2;
    for (int i = 0; i < 3; i++) begin
      if (state_reg.pin_s2[i] == state_reg.pin_s3[i]) begin
        state_next.pin_lvl[i] = state_reg.pin_s3[i];
      end
    end
    state_next.pin_dly[0] = state_reg.pin_lvl;
    state_next.pin_dly[1] = state_reg.pin_dly[0];

    // [R11] pending sync load counts down, then lands
    if (state_reg.ld_pend) begin
      if (state_reg.ld_wait == 2'd0) begin
        state_next = commit_load(state_next, state_reg.ld_phase, state_reg.ld_addr, state_reg.ld_value);
        state_next.ld_pend = 1'b0;
      end else begin
        state_next.ld_wait = state_reg.ld_wait - 2'd1;
      end
    end

    // serial words win; a bus word waits one cycle behind them
    if (rx_words.valid) begin
      state_next = apply_word(state_next, rx_words.word);
    end else if (state_reg.apb_pend) begin
      state_next = apply_word(state_next, state_reg.apb_word);
      state_next.apb_pend = 1'b0;
    end

    // bus write of a command word
    if (access && pwrite && paddr == `OFF_CMD_WORD) begin
      if (rx_words.valid || state_reg.apb_pend) begin
        state_next.apb_pend = 1'b1;
        state_next.apb_word = pwdata[15:0];
      end else begin
        state_next = apply_word(state_next, pwdata[15:0]);
      end
    end

    // read data and error prepared in the setup cycle
    if (setup) begin
      state_next.err = !addr_known(paddr);
      state_next.rdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `OFF_STATUS: begin
            state_next.rdata[`ST_SYNC] = state_reg.sync_on;
            state_next.rdata[`ST_PICK_SRC] = state_reg.pick_from_bits;
            state_next.rdata[`ST_SLEEP] = state_reg.sleep;
            state_next.rdata[`ST_ACC_RESET] = state_reg.acc_reset;
            state_next.rdata[`ST_FSEL] = active_fsel;
            state_next.rdata[`ST_PSEL_LO +: 2] = active_psel;
            state_next.rdata[`ST_LOAD_BUSY] = state_reg.ld_pend;
          end
          `OFF_PHASE_OUT: state_next.rdata[11:0] = sine_phase;
          `OFF_FREQ_ACTIVE: state_next.rdata = active_step;
          `OFF_LAST_WORD: state_next.rdata[15:0] = state_reg.last_word;
          default: state_next.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // [R22] control bits start at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states: every access ends in its first access cycle
  assign pready = access;
  assign pslverr = access && state_reg.err;
  assign prdata = state_reg.rdata;
  // [R14] power-down outputs
  assign power_down = state_reg.sleep;
  assign reference_output = !state_reg.sleep;

endmodule

`default_nettype wire

// ==== sim/serial_host.sv ====
/*
  Host model of the serial write link: frames one 16-bit word at a time.
  Assumes pclk at 100 ns; shift clock period is eight pclk cycles.
*/
`default_nettype none

module serial_host (
  input wire logic pclk,
  output logic serial_clk,
  output logic serial_in,
  output logic frame_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    serial_clk = 1'b1;
    serial_in = 1'b0;
    frame_strobe_n = 1'b1;
  end

  // reserved code never sent by the callers
  // shift clock stands high between frames; data line flips once released
  task automatic send(input logic [15:0] w);
    @(posedge pclk);
    frame_strobe_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (4) @(posedge pclk);
      serial_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      serial_clk <= 1'b1;
    end
    frame_strobe_n <= 1'b1;
    serial_in <= ~w[0];
  endtask
endmodule

`default_nettype wire

// ==== sim/dds_command_decoder_properties.sv ====
/*
  Concurrent checks on the decoder's bus and power pins.
  Assumes it is bound onto the decoder top module.
*/
`default_nettype none

module dds_command_decoder_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] sine_phase,
  input wire logic power_down,
  input wire logic reference_output
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence

  chk_ready_no_wait: assert property (setup_s ##1 access_s |-> pready)
    else $error("pready missing in access cycle");
  chk_ready_idle: assert property (!psel |-> !pready)
    else $error("pready without select");
  chk_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_cmd_reads_zero: assert property (psel && penable && !pwrite && paddr == 8'h00 |-> prdata == 32'h0)
    else $error("command port read not zero");
  // read data stands after the access until the next setup
  chk_rdata_holds: assert property (access_s ##1 !psel |-> $stable(prdata))
    else $error("prdata moved after access");
  // the second sleeping cycle still shows the last advance; from then on nothing moves
  chk_sleep_ref_off: assert property (power_down [*3] |-> !reference_output && $stable(sine_phase))
    else $error("reference on or phase moving while powered down");
endmodule

`default_nettype wire

////////////////////////////////////////////////////////////////////////////
bind dds_command_decoder dds_command_decoder_checker dds_command_decoder_checker_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sine_phase(sine_phase), .power_down(power_down), .reference_output(reference_output)
);

// ==== sim/dds_command_decoder_bench.sv ====
/*
  Self-checking bench of the command decoder: APB tasks and a serial host.
  Assumes package, interface, header and design files are compiled first.
*/
`default_nettype none
`include "dds_cmd_regs.svh"

`define CHECK(what, exp, got) \
  begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end

module dds_command_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic serial_clk, serial_in, frame_strobe_n, freq_pick, phase_pick_lo, phase_pick_hi;
  logic [11:0] sine_phase, p0;
  logic power_down, reference_output, re;
  int compares = 0;
  int bad_count = 0;
  int cycles = 0;

  dds_command_decoder dds_command_decoder_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(serial_clk), .serial_in(serial_in), .frame_strobe_n(frame_strobe_n),
    .freq_pick(freq_pick), .phase_pick_lo(phase_pick_lo), .phase_pick_hi(phase_pick_hi),
    .sine_phase(sine_phase), .power_down(power_down), .reference_output(reference_output)
  );
  serial_host serial_host_inst (
    .pclk(pclk), .serial_clk(serial_clk), .serial_in(serial_in), .frame_strobe_n(frame_strobe_n)
  );

  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hung handshake must not stall the run forever
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the run's own timeout ends a wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic cmd_bus(input logic [15:0] w);
    apb(`OFF_CMD_WORD, 1'b1, {16'h0, w});
    tick(4);
  endtask

  task automatic cmd_ser(input logic [15:0] w);
    serial_host_inst.send(w);
    tick(10);
  endtask

  task automatic stat(input logic [7:0] exp);
    apb(`OFF_STATUS, 1'b0, 32'h0);
    `CHECK("status", exp, rq[7:0])
  endtask

  task automatic pins(input logic f, input logic h, input logic l);
    @(posedge pclk);
    freq_pick <= f;
    phase_pick_hi <= h;
    phase_pick_lo <= l;
    tick(8);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    freq_pick = 1'b0;
    phase_pick_lo = 1'b0;
    phase_pick_hi = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    stat(8'h00);
    `CHECK("reference_output", 1'b1, reference_output)
    apb(8'h14, 1'b0, 32'h0);
    `CHECK("unmapped", 1'b1, re)
    cmd_ser(16'h9fff);
    stat(8'h02);
    apb(`OFF_LAST_WORD, 1'b0, 32'h0);
    `CHECK("last word", 32'h0000_9fff, rq)
    cmd_bus(16'h4400);
    stat(8'h42);
    cmd_ser(16'h1c34);
    `CHECK("phase", 12'h000, sine_phase)
    cmd_ser(16'h0d0a);
    `CHECK("phase", 12'ha34, sine_phase)
    cmd_ser(16'h6200);
    stat(8'h22);
    `CHECK("phase", 12'h000, sine_phase)
    cmd_bus(16'h5800);
    stat(8'h32);
    cmd_ser(16'hc800);
    stat(8'h00);
    cmd_bus(16'h9000);
    stat(8'h32);
    cmd_bus(16'hc800);
    pins(1'b0, 1'b1, 1'b0);
    stat(8'h40);
    `CHECK("phase", 12'ha34, sine_phase)
    pins(1'b0, 1'b0, 1'b1);
    stat(8'h20);
    `CHECK("phase", 12'h000, sine_phase)
    cmd_bus(16'h3210);
    apb(`OFF_FREQ_ACTIVE, 1'b0, 32'h0);
    `CHECK("tuning", 32'h0, rq)
    cmd_bus(16'h2300);
    apb(`OFF_FREQ_ACTIVE, 1'b0, 32'h0);
    `CHECK("tuning", 32'h0010_0000, rq)
    p0 = sine_phase;
    tick(10);
    `CHECK("advance", p0 + 12'd10, sine_phase)
    pins(1'b1, 1'b1, 1'b0);
    apb(`OFF_FREQ_ACTIVE, 1'b0, 32'h0);
    `CHECK("tuning", 32'h0, rq)
    pins(1'b0, 1'b1, 1'b0);
    cmd_ser(16'hd000);
    stat(8'h48);
    `CHECK("phase", 12'ha34, sine_phase)
    cmd_bus(16'hc000);
    cmd_bus(16'he000);
    `CHECK("sleep", 1'b1, power_down)
    `CHECK("reference_output", 1'b0, reference_output)
    p0 = sine_phase;
    tick(10);
    `CHECK("frozen", p0, sine_phase)
    cmd_bus(16'hc000);
    `CHECK("sleep", 1'b0, power_down)
    cmd_bus(16'hb000);
    stat(8'h33);
    p0 = sine_phase;
    cmd_bus(16'h1a05);
    cmd_bus(16'h0b01);
    `CHECK("phase", p0 + 12'h105, sine_phase)
    wrap_up();
  end
endmodule

`default_nettype wire
